/* File: fpes_host.sv */
// Purpose: host controller issuing program and erase sequences to a flash
// Assumes: flash data pins are two-way, ready/busy is an open-drain input
// Notes: completion is taken from ready/busy and from the polling bit
`timescale 1ns/10ps
module fpes_host
  import fpes_pkg::*;
#(
  parameter int WINDOW_CYC = FPES_WINDOW_CYC,
  parameter int BUSY_TIMEOUT_CYC = 24'hffffff
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  input wire fpes_op_t REQ_OP_I,
  input wire fpes_bus_t REQ_I,
  input wire logic BYTE_MODE_I,
  input wire logic ACCEL_I,
  output logic REQ_READY_O,
  output logic DONE_O,
  output logic FAIL_O,
  output logic WINDOW_OPEN_O,
  output logic [19:0] FLASH_ADDR_O,
  output logic [15:0] FLASH_DQ_O,
  output logic FLASH_DQ_OE_N_O,
  input wire logic [15:0] FLASH_DQ_I,
  input wire logic FLASH_READY_BUSY_OUT_I,
  output logic FLASH_WE_N_O,
  output logic FLASH_OE_N_O,
  output logic FLASH_CE_N_O,
  output logic FLASH_BYTE_N_O,
  output logic FLASH_ACCEL_O
);
  typedef enum logic [2:0] {FPES_IDLE, FPES_ISSUE, FPES_WAIT,
    FPES_POLL, FPES_FINISH} fpes_state_t;

  logic rst_s1_reg, rst_n;
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] rb_sync_reg;
  logic rb_reg;
  logic [15:0] dq_s1_reg, dq_s2_reg, dq_s3_reg;
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      rb_sync_reg <= 3'h7;
      rb_reg <= 1'b1;
      dq_s1_reg <= 16'h0000;
      dq_s2_reg <= 16'h0000;
      dq_s3_reg <= 16'h0000;
    end else begin
      rb_sync_reg <= {rb_sync_reg[1:0], FLASH_READY_BUSY_OUT_I};
      if (rb_sync_reg[1] == rb_sync_reg[2]) begin
        rb_reg <= rb_sync_reg[2];
      end
      dq_s1_reg <= FLASH_DQ_I;
      dq_s2_reg <= dq_s1_reg;
      dq_s3_reg <= dq_s2_reg;
    end
  end

  // ****************************************
  // sequence tables
  // ****************************************
  fpes_state_t st_reg;
  fpes_op_t op_reg;
  fpes_bus_t req_reg;
  logic [2:0] idx_reg;
  logic bypass_reg;
  logic [23:0] tmr_reg;
  wire [19:0] u1 = FPES_ADDR_UNLOCK1;
  wire [19:0] u2 = FPES_ADDR_UNLOCK2;
  logic [2:0] seq_len;
  logic [19:0] seq_addr;
  logic [7:0] seq_cmd;
  logic seq_last_data;
  logic seq_waits;

  always_comb begin
    seq_len = 3'h1;
    seq_addr = u1;
    seq_cmd = FPES_CMD_RESET;
    seq_last_data = 1'b0;
    seq_waits = 1'b0;
    case (op_reg)
      FPES_OP_PROGRAM: begin
        seq_len = 3'h4;
        seq_waits = 1'b1;
        seq_last_data = (idx_reg == 3'h3);
        seq_addr = (idx_reg == 3'h1) ? u2 : u1;
        seq_cmd = (idx_reg == 3'h0) ? FPES_CMD_UNLOCK1 :
          (idx_reg == 3'h1) ? FPES_CMD_UNLOCK2 : FPES_CMD_PROGRAM;
      end
      FPES_OP_BYP_ENTER: begin
        seq_len = 3'h3;
        seq_addr = (idx_reg == 3'h1) ? u2 : u1;
        seq_cmd = (idx_reg == 3'h0) ? FPES_CMD_UNLOCK1 :
          (idx_reg == 3'h1) ? FPES_CMD_UNLOCK2 : FPES_CMD_BYPASS;
      end
      FPES_OP_BYP_PROGRAM: begin
        seq_len = 3'h2;
        seq_waits = 1'b1;
        seq_last_data = (idx_reg == 3'h1);
        seq_cmd = FPES_CMD_PROGRAM;
      end
      FPES_OP_BYP_EXIT: begin
        seq_len = 3'h2;
        seq_cmd = (idx_reg == 3'h0) ? FPES_CMD_BYP_EXIT1 :
          FPES_CMD_BYP_EXIT2;
      end
      FPES_OP_CHIP_ERASE, FPES_OP_SECTOR_ERASE: begin
        seq_len = 3'h6;
        seq_waits = (op_reg == FPES_OP_CHIP_ERASE);
        // second unlock pair follows the setup write: 3 is AA, 4 is 55
        seq_addr = (idx_reg == 3'h1 || idx_reg == 3'h4) ? u2 : u1;
        seq_cmd = (idx_reg == 3'h2) ? FPES_CMD_ERASE_SETUP :
          (idx_reg == 3'h1 || idx_reg == 3'h4) ? FPES_CMD_UNLOCK2 :
          FPES_CMD_UNLOCK1;
        if (idx_reg == 3'h5) begin
          seq_addr = (op_reg == FPES_OP_CHIP_ERASE) ? u1 : req_reg.addr;
          seq_cmd = (op_reg == FPES_OP_CHIP_ERASE) ? FPES_CMD_CHIP_ERASE :
            FPES_CMD_SECTOR_ERASE;
        end
      end
      FPES_OP_SECTOR_ADD: begin
        seq_addr = req_reg.addr;
        seq_cmd = FPES_CMD_SECTOR_ERASE;
      end
      default: begin
        seq_cmd = FPES_CMD_RESET;
      end
    endcase
  end

  // only program and exit allowed in bypass; accel forces it
  wire in_bypass = bypass_reg || ACCEL_I;
  wire op_legal = in_bypass ?
    (REQ_OP_I == FPES_OP_BYP_PROGRAM || REQ_OP_I == FPES_OP_BYP_EXIT) :
    (REQ_OP_I == FPES_OP_SECTOR_ADD ? WINDOW_OPEN_O :
     REQ_OP_I != FPES_OP_BYP_PROGRAM && REQ_OP_I != FPES_OP_BYP_EXIT);
  wire [15:0] last_data = req_reg.data;
  wire [15:0] cmd_word = {8'h00, seq_cmd};

  logic cyc_start, cyc_busy, cyc_done, we_n, oe_n, ce_n;
  fpes_bus_cycle u_cycle (
    .clk_i(CLOCK_I),
    .rst_n_i(rst_n),
    .start_i(cyc_start),
    .write_i(st_reg == FPES_ISSUE),
    .busy_o(cyc_busy),
    .done_o(cyc_done),
    .we_n_o(we_n),
    .oe_n_o(oe_n),
    .ce_n_o(ce_n)
  );
  assign cyc_start = !cyc_busy && !cyc_done &&
    (st_reg == FPES_ISSUE || st_reg == FPES_POLL);

  wire tmr_zero = (tmr_reg == 24'h0);
  // ready drops a cycle early so no request meets the window expiry
  wire win_near = WINDOW_OPEN_O && (tmr_reg <= 24'h1);
  wire win_expire = WINDOW_OPEN_O && tmr_zero && (st_reg == FPES_IDLE);
  wire sect_op = (op_reg == FPES_OP_SECTOR_ERASE ||
    op_reg == FPES_OP_SECTOR_ADD);
  // done when ready and polling bit shows true data
  wire poll_ok = rb_reg &&
    (dq_s2_reg[FPES_RDY_BIT] == dq_s3_reg[FPES_RDY_BIT]) &&
    (dq_s3_reg[FPES_RDY_BIT] == req_reg.data[FPES_RDY_BIT]);

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= FPES_IDLE;
      op_reg <= FPES_OP_RESET;
      req_reg <= '0;
      idx_reg <= 3'h0;
      bypass_reg <= 1'b0;
      tmr_reg <= 24'h0;
      REQ_READY_O <= 1'b0;
      DONE_O <= 1'b0;
      FAIL_O <= 1'b0;
      WINDOW_OPEN_O <= 1'b0;
      FLASH_ADDR_O <= '0;
      FLASH_DQ_O <= 16'h0000;
      FLASH_DQ_OE_N_O <= 1'b1;
      FLASH_WE_N_O <= 1'b1;
      FLASH_OE_N_O <= 1'b1;
      FLASH_CE_N_O <= 1'b1;
      FLASH_BYTE_N_O <= 1'b1;
      FLASH_ACCEL_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      FAIL_O <= 1'b0;
      FLASH_WE_N_O <= we_n;
      FLASH_OE_N_O <= oe_n;
      FLASH_CE_N_O <= ce_n;
      FLASH_BYTE_N_O <= !BYTE_MODE_I;
      FLASH_ACCEL_O <= ACCEL_I;
      // data stays driven one cycle past the strobe rise
      FLASH_DQ_OE_N_O <= 1'b1;
      // window counted from last strobe rise
      if (WINDOW_OPEN_O && !tmr_zero) begin
        tmr_reg <= tmr_reg - 24'h1;
      end
      // expiry waits for a write in flight to finish
      if (win_expire) begin
        WINDOW_OPEN_O <= 1'b0;
        st_reg <= FPES_WAIT;
        REQ_READY_O <= 1'b0;
        tmr_reg <= 24'(BUSY_TIMEOUT_CYC);
      end
      case (st_reg)
        FPES_IDLE: begin
          REQ_READY_O <= !win_near;
          if (REQ_VALID_I && REQ_READY_O) begin
            REQ_READY_O <= 1'b0;
            if (op_legal) begin
              // leaving the window by any accepted command other than sector add
              if (REQ_OP_I != FPES_OP_SECTOR_ADD) begin
                WINDOW_OPEN_O <= 1'b0;
              end
              op_reg <= REQ_OP_I;
              req_reg <= REQ_I;
              idx_reg <= 3'h0;
              st_reg <= FPES_ISSUE;
            end else begin
              FAIL_O <= 1'b1;
            end
          end
        end
        FPES_ISSUE: begin
          FLASH_ADDR_O <= seq_last_data ? req_reg.addr : seq_addr;
          FLASH_DQ_O <= seq_last_data ? last_data : cmd_word;
          FLASH_DQ_OE_N_O <= 1'b0;
          if (cyc_done) begin
            if (idx_reg == seq_len - 3'h1) begin
              tmr_reg <= 24'(BUSY_TIMEOUT_CYC);
              if (op_reg == FPES_OP_BYP_ENTER) begin
                bypass_reg <= 1'b1;
              end
              if (op_reg == FPES_OP_BYP_EXIT) begin
                bypass_reg <= 1'b0;
              end
              if (op_reg == FPES_OP_SECTOR_ERASE ||
                  op_reg == FPES_OP_SECTOR_ADD) begin
                // more sector writes accepted until the window shuts; none once erase runs
                WINDOW_OPEN_O <= 1'b1;
                tmr_reg <= 24'(WINDOW_CYC - 1);
                st_reg <= FPES_IDLE;
              end else begin
                st_reg <= seq_waits ? FPES_WAIT : FPES_FINISH;
              end
              if (op_reg == FPES_OP_CHIP_ERASE) begin
                req_reg.data <= 16'hffff;
              end
            end else begin
              idx_reg <= idx_reg + 3'h1;
            end
          end
        end
        // no writes while the device is busy
        FPES_WAIT: begin
          if (op_reg == FPES_OP_SECTOR_ERASE ||
              op_reg == FPES_OP_SECTOR_ADD) begin
            req_reg.data <= 16'hffff;
          end
          FLASH_ADDR_O <= req_reg.addr;
          if (tmr_zero) begin
            FAIL_O <= 1'b1;
            st_reg <= FPES_IDLE;
          end else begin
            tmr_reg <= tmr_reg - 24'h1;
            if (!cyc_busy) begin
              st_reg <= FPES_POLL;
            end
          end
        end
        FPES_POLL: begin
          if (!tmr_zero) begin
            tmr_reg <= tmr_reg - 24'h1;
          end
          if (cyc_done) begin
            st_reg <= FPES_FINISH;
          end
        end
        FPES_FINISH: begin
          // device back in array read on success
          if (!(seq_waits || sect_op) || poll_ok) begin
            DONE_O <= 1'b1;
            st_reg <= FPES_IDLE;
          end else if (!cyc_busy) begin
            st_reg <= FPES_WAIT;
          end
        end
        default: st_reg <= FPES_IDLE;
      endcase
    end
  end
endmodule // fpes_host

/* File: fpes_pkg.sv */
// Purpose: shared constants and types for the flash program/erase host
// Assumes: 200 MHz clock, parallel flash with write strobe and chip select
// Notes: unlock addresses given in word mode
package fpes_pkg;
  localparam int FPES_AW = 20;
  localparam int FPES_DW = 16;
  localparam logic [19:0] FPES_ADDR_UNLOCK1 = 20'h00555;
  localparam logic [19:0] FPES_ADDR_UNLOCK2 = 20'h002aa;
  localparam logic [7:0] FPES_CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] FPES_CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] FPES_CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] FPES_CMD_BYPASS = 8'h20;
  localparam logic [7:0] FPES_CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] FPES_CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] FPES_CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] FPES_CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] FPES_CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] FPES_CMD_RESET = 8'hf0;
  // write strobe timing, in clock cycles
  localparam int FPES_SETUP_CYC = 4;
  localparam int FPES_PULSE_CYC = 8;
  localparam int FPES_HOLD_CYC = 4;
  // sector erase window
  localparam int FPES_WINDOW_US = 50;
  localparam int FPES_CLK_MHZ = 200;
  localparam int FPES_WINDOW_CYC = FPES_WINDOW_US * FPES_CLK_MHZ;
  // poll interval between status reads
  localparam int FPES_POLL_CYC = 16;
  localparam int FPES_RDY_BIT = 7;

  typedef enum logic [2:0] {
    FPES_OP_PROGRAM,
    FPES_OP_BYP_ENTER,
    FPES_OP_BYP_PROGRAM,
    FPES_OP_BYP_EXIT,
    FPES_OP_CHIP_ERASE,
    FPES_OP_SECTOR_ERASE,
    FPES_OP_SECTOR_ADD,
    FPES_OP_RESET
  } fpes_op_t;

  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] data;
  } fpes_bus_t;
endpackage

/* File: fpes_bus_cycle.sv */
// Purpose: one write or read cycle on the flash parallel bus
// Assumes: caller holds address and data stable while busy
// Notes: write strobe low for a fixed count of cycles
`timescale 1ns/10ps
module fpes_bus_cycle
  import fpes_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic write_i,
  output logic busy_o,
  output logic done_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic ce_n_o
);
  typedef enum logic [1:0] {FPES_C_IDLE, FPES_C_SETUP, FPES_C_PULSE,
    FPES_C_HOLD} fpes_cyc_t;
  fpes_cyc_t st_reg;
  logic [3:0] cnt_reg;
  logic wr_reg;
  wire cnt_end = (cnt_reg == 4'h0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= FPES_C_IDLE;
      cnt_reg <= 4'h0;
      wr_reg <= 1'b0;
      done_o <= 1'b0;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      ce_n_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (st_reg)
        FPES_C_IDLE: begin
          if (start_i) begin
            st_reg <= FPES_C_SETUP;
            wr_reg <= write_i;
            ce_n_o <= 1'b0;
            cnt_reg <= 4'(FPES_SETUP_CYC - 1);
          end
        end
        FPES_C_SETUP: begin
          if (cnt_end) begin
            // address latched on the falling strobe edge
            st_reg <= FPES_C_PULSE;
            we_n_o <= !wr_reg;
            oe_n_o <= wr_reg;
            cnt_reg <= 4'(FPES_PULSE_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FPES_C_PULSE: begin
          if (cnt_end) begin
            // data latched on the rising strobe edge
            st_reg <= FPES_C_HOLD;
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            done_o <= 1'b1;
            cnt_reg <= 4'(FPES_HOLD_CYC - 1);
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        FPES_C_HOLD: begin
          if (cnt_end) begin
            st_reg <= FPES_C_IDLE;
            ce_n_o <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: st_reg <= FPES_C_IDLE;
      endcase
    end
  end
  assign busy_o = (st_reg != FPES_C_IDLE);
endmodule // fpes_bus_cycle

/* File: fpes_host_properties.sv */
// Purpose: port checks on the flash program/erase host
// Assumes: sees only fpes_host ports
// Notes: bound from the testbench top file
`timescale 1ns/10ps
module fpes_host_chk (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic REQ_VALID_I,
  input wire logic REQ_READY_O,
  input wire logic DONE_O,
  input wire logic FAIL_O,
  input wire logic WINDOW_OPEN_O,
  input wire logic ACCEL_I,
  input wire logic FLASH_ACCEL_O,
  input wire logic [19:0] FLASH_ADDR_O,
  input wire logic [15:0] FLASH_DQ_O,
  input wire logic FLASH_DQ_OE_N_O,
  input wire logic FLASH_READY_BUSY_OUT_I,
  input wire logic FLASH_WE_N_O,
  input wire logic FLASH_OE_N_O,
  input wire logic FLASH_CE_N_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  chk_dq_driven: assert property (
    !FLASH_WE_N_O |-> !FLASH_DQ_OE_N_O && !FLASH_CE_N_O)
    else $error("write strobe without driven data");
  chk_read_release: assert property (
    !FLASH_OE_N_O |-> FLASH_DQ_OE_N_O && FLASH_WE_N_O)
    else $error("read while host drives data");
  chk_we_width: assert property (
    $fell(FLASH_WE_N_O) |-> !FLASH_WE_N_O [*8] ##1 FLASH_WE_N_O)
    else $error("write strobe width wrong");
  chk_addr_hold: assert property (
    !FLASH_WE_N_O && $past(!FLASH_WE_N_O)
      |-> $stable(FLASH_ADDR_O) && $stable(FLASH_DQ_O))
    else $error("address or data moved in strobe");
  chk_busy_quiet: assert property (
    !FLASH_READY_BUSY_OUT_I [*4] |-> FLASH_WE_N_O)
    else $error("write while device busy");
  chk_one_answer: assert property (
    !(DONE_O && FAIL_O))
    else $error("done and fail together");
  chk_take_drop: assert property (
    REQ_VALID_I && REQ_READY_O |=> !REQ_READY_O)
    else $error("ready held after take");
  chk_accel_follow: assert property (
    $changed(ACCEL_I) |-> ##[0:4] FLASH_ACCEL_O == ACCEL_I)
    else $error("accel output lags");
  chk_window_quiet: assert property (
    WINDOW_OPEN_O |-> FLASH_OE_N_O)
    else $error("read inside erase window");
  cov_done: cover property (DONE_O);
  cov_fail: cover property (FAIL_O);
  cov_window: cover property ($rose(WINDOW_OPEN_O));
endmodule // fpes_host_chk

/* File: fpes_flash_model.sv */
// Purpose: behavioural flash device on the far side of the host
// Assumes: 1024 words, sector is addr[9:8]
// Notes: timed in ns, not in strobe counts
`timescale 1ns/10ps
module fpes_flash_model
  import fpes_pkg::*;
#(
  parameter int BUSY_NS = 400,
  parameter int WIN_NS = 300
) (
  input wire logic [19:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic ce_n_i,
  input wire logic accel_i,
  output logic [15:0] dq_o,
  output logic ready_busy_out_o
);
  logic [15:0] mem [0:1023];
  logic [15:0] pd = 16'hffff;
  logic [19:0] la;
  logic [3:0] sec;
  logic [7:0] cmd;
  logic [15:0] val;
  logic busy = 0, win = 0, byp = 0, tg = 0;
  int st = 0, gen = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  assign cmd = dq_i[7:0];
  assign val = (busy || win) ? {8'h00, ~pd[7], tg, 2'b00, ~win, tg, 2'b00}
                             : mem[addr_i[9:0]];
  // released bus shows the inverse, not a held value
  assign dq_o = (!oe_n_i && !ce_n_i) ? val : ~val;
  assign ready_busy_out_o = !busy;
  always @(negedge oe_n_i) tg = ~tg;
  always @(negedge we_n_i) la = addr_i;
  always @(posedge busy) begin
    #BUSY_NS;
    busy = 0;
  end
  always @(gen) fork
    automatic int g = gen;
    #WIN_NS if (g == gen && win) begin
      win = 0;
      for (int i = 0; i < 1024; i++) if (sec[i[9:8]]) mem[i] = 16'hffff;
      busy = 1;
    end
  join_none
  always @(posedge we_n_i) if (!ce_n_i && !busy) begin
    if (win) begin
      if (cmd == FPES_CMD_SECTOR_ERASE) begin
        sec[la[9:8]] = 1;
        gen++;
      end else win = 0;
    end else if (cmd == FPES_CMD_RESET && !byp) st = 0;
    else if (st == 3) begin
      mem[la[9:0]] &= dq_i;
      pd = dq_i;
      st = 0;
      busy = 1;
    end else if (byp || accel_i) begin
      if (st == 7 && cmd == FPES_CMD_BYP_EXIT2) byp = 0;
      st = (cmd == FPES_CMD_PROGRAM) ? 3 : (cmd == FPES_CMD_BYP_EXIT1) ? 7 : 0;
    end else if ((st == 0 || st == 4) && la == FPES_ADDR_UNLOCK1
                 && cmd == FPES_CMD_UNLOCK1) st++;
    else if ((st == 1 || st == 5) && la == FPES_ADDR_UNLOCK2
             && cmd == FPES_CMD_UNLOCK2) st++;
    else if (st == 2 && cmd == FPES_CMD_PROGRAM) st = 3;
    else if (st == 2 && cmd == FPES_CMD_BYPASS) begin
      byp = 1;
      st = 0;
    end else if (st == 2 && cmd == FPES_CMD_ERASE_SETUP) st = 4;
    else if (st == 6 && cmd == FPES_CMD_CHIP_ERASE) begin
      foreach (mem[i]) mem[i] = 16'hffff;
      pd = 16'hffff;
      st = 0;
      busy = 1;
    end else if (st == 6 && cmd == FPES_CMD_SECTOR_ERASE) begin
      sec = 4'h0;
      sec[la[9:8]] = 1;
      pd = 16'hffff;
      win = 1;
      st = 0;
      gen++;
    end else st = 0;
  end
endmodule // fpes_flash_model

/* File: test_fpes_host.sv */
// Purpose: self-checking bench for the flash program/erase host
// Assumes: word mode, small window and timeout
// Notes: memory expectation kept in exp_mem
`timescale 1ns/10ps
bind fpes_host fpes_host_chk u_chk (.*);
module test_fpes_host;
  import fpes_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, accel = 0, ry, rdy, done, fail, win;
  logic dq_oe_n, we_n, oe_n, ce_n, acc_o, byte_n;
  logic byte_m = 0;
  fpes_op_t op = FPES_OP_RESET;
  fpes_bus_t req = '0;
  logic [19:0] fa;
  logic [15:0] dq_h, dq_f, dq_w;
  logic [15:0] exp_mem [0:1023];
  int fail_count = 0, tests_run = 0;
  int unsigned seed = 13;
  always #2.5 clk = ~clk;
  assign dq_w = dq_oe_n ? dq_f : dq_h;
  fpes_host #(.WINDOW_CYC(50), .BUSY_TIMEOUT_CYC(2000)) u_dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld), .REQ_OP_I(op),
    .REQ_I(req), .BYTE_MODE_I(byte_m), .ACCEL_I(accel), .REQ_READY_O(rdy),
    .DONE_O(done), .FAIL_O(fail), .WINDOW_OPEN_O(win), .FLASH_ADDR_O(fa),
    .FLASH_DQ_O(dq_h), .FLASH_DQ_OE_N_O(dq_oe_n), .FLASH_DQ_I(dq_w),
    .FLASH_READY_BUSY_OUT_I(ry), .FLASH_WE_N_O(we_n), .FLASH_OE_N_O(oe_n),
    .FLASH_CE_N_O(ce_n), .FLASH_BYTE_N_O(byte_n), .FLASH_ACCEL_O(acc_o));
  fpes_flash_model u_flash (.addr_i(fa), .dq_i(dq_w), .we_n_i(we_n),
    .oe_n_i(oe_n), .ce_n_i(ce_n), .accel_i(acc_o), .dq_o(dq_f),
    .ready_busy_out_o(ry));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic send(input fpes_op_t o, input logic [9:0] a,
                      input logic [15:0] d);
    int n = 0;
    while (rdy !== 1'b1 && n < 5000) begin @(negedge clk); n++; end
    if (n == 5000) begin fail_count++; close_out(); end
    op = o;
    req = '{{10'h0, a}, d};
    vld = 1;
    @(negedge clk);
    vld = 0;
  endtask
  task automatic await(input logic want_fail);
    int n = 0;
    while (done !== 1'b1 && fail !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    if (n == 5000) begin fail_count++; close_out(); end
    chk(16'(fail), 16'(want_fail));
    @(negedge clk);
  endtask
  task automatic prog(input fpes_op_t o, input logic [9:0] a,
                      input logic [15:0] d);
    logic bad;
    bad = d[7] & ~exp_mem[a][7];
    send(o, a, d);
    await(bad);
    exp_mem[a] = exp_mem[a] & d;
    chk(u_flash.mem[a], exp_mem[a]);
  endtask
  task automatic sweep();
    foreach (exp_mem[i]) chk(u_flash.mem[i], exp_mem[i]);
  endtask
  initial begin
    logic [31:0] r;
    logic [9:0] a;
    foreach (exp_mem[i]) exp_mem[i] = 16'hffff;
    repeat (2) @(negedge clk);
    rst_n = 1;
    // width select only toggled while idle; the model is word wide
    byte_m = 1;
    repeat (4) @(negedge clk);
    chk(16'(byte_n), 16'h0);
    byte_m = 0;
    repeat (2) @(negedge clk);
    chk(16'(byte_n), 16'h1);
    // odd passes hit the same word again, trying to raise some bits
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      if (!i[0]) a = r[9:0];
      prog(FPES_OP_PROGRAM, a, r[31:16]);
    end
    send(FPES_OP_BYP_PROGRAM, 10'h0, 16'h0);
    await(1);
    send(FPES_OP_SECTOR_ADD, 10'h0, 16'h0);
    await(1);
    send(FPES_OP_BYP_ENTER, 10'h0, 16'h0);
    await(0);
    for (int i = 0; i < 3; i++) begin
      r = rnd();
      prog(FPES_OP_BYP_PROGRAM, r[9:0], r[31:16]);
    end
    send(FPES_OP_PROGRAM, 10'h0, 16'h0);
    await(1);
    send(FPES_OP_BYP_EXIT, 10'h0, 16'h0);
    await(0);
    accel = 1;
    repeat (4) @(negedge clk);
    r = rnd();
    prog(FPES_OP_BYP_PROGRAM, r[9:0], r[31:16]);
    send(FPES_OP_CHIP_ERASE, 10'h0, 16'h0);
    await(1);
    accel = 0;
    repeat (4) @(negedge clk);
    send(FPES_OP_RESET, 10'h0, 16'h0);
    await(0);
    send(FPES_OP_SECTOR_ERASE, 10'h100, 16'h0);
    for (int n = 0; n < 500 && win !== 1'b1; n++) @(negedge clk);
    chk(16'(win), 16'h1);
    send(FPES_OP_SECTOR_ADD, 10'h300, 16'h0);
    await(0);
    foreach (exp_mem[i]) if (i[8]) exp_mem[i] = 16'hffff;
    sweep();
    send(FPES_OP_CHIP_ERASE, 10'h0, 16'h0);
    await(0);
    foreach (exp_mem[i]) exp_mem[i] = 16'hffff;
    sweep();
    close_out();
  end
endmodule // test_fpes_host
